// File: verilog/fhrs_defines.vh
`ifndef FHRS_DEFINES_VH
`define FHRS_DEFINES_VH
// ==========================================================
// Register indices, byte address is four times the index
`define FHRS_IDX_DRIVE_CTRL 10'h3f2
`define FHRS_IDX_STATUS     10'h3f4
`define FHRS_IDX_DATA       10'h3f5
`define FHRS_IDX_DIR        10'h3f7
`define FHRS_IDX_FORCE_CHG  10'h01e
`define FHRS_IDX_SHADOW     10'h01f
`define FHRS_IDX_CONFIG     10'h020
// ==========================================================
// Field positions
`define FHRS_RS_SRST        7
`define FHRS_RS_LP          6
`define FHRS_RS_PC_HI       4
`define FHRS_RS_PC_LO       2
`define FHRS_DC_RESET_N     2
`define FHRS_CFG_FIFO_EN    0
`define FHRS_CFG_THR_HI     7
`define FHRS_CFG_THR_LO     4
`define FHRS_CFG_DRT_HI     9
`define FHRS_CFG_DRT_LO     8
`define FHRS_CFG_DT_HI      11
`define FHRS_CFG_DT_LO      10
`define FHRS_CFG_TRK_HI     23
`define FHRS_CFG_TRK_LO     16
// ==========================================================
// Reset values
`define FHRS_RS_RESET       8'h02
`define FHRS_DC_RESET       8'h00
`define FHRS_CFG_RESET      24'h000000
// ==========================================================
// Rate select codes and resulting speeds
`define FHRS_RATE_1M        2'b11
`define FHRS_RATE_500K      2'b00
`define FHRS_RATE_300K      2'b01
`define FHRS_RATE_250K      2'b10
`define FHRS_SPD_250K       3'h0
`define FHRS_SPD_300K       3'h1
`define FHRS_SPD_500K       3'h2
`define FHRS_SPD_1M         3'h3
`define FHRS_SPD_2M         3'h4
`define FHRS_DRT_THREE_MODE 2'b01
`define FHRS_DRT_TAPE       2'b10
// ==========================================================
// Precompensation, in picoseconds
`define FHRS_PC_STEP_PS     18'h0a2c6
`define FHRS_PC_STEP_2M_PS  18'h05140
`define FHRS_PC_DEF_PS      18'h1e848
`define FHRS_PC_DEF_CODE    3'h7
// ==========================================================
// Timing
`define FHRS_CLK_NS         10
`define FHRS_SRST_NS        100
`define FHRS_SRST_CYC       ((`FHRS_SRST_NS + `FHRS_CLK_NS - 1) / `FHRS_CLK_NS)
`define FHRS_FIFO_DEPTH     16
`endif

// File: verilog/fhrs_host_port.v
`timescale 1ns/1ns
`include "fhrs_defines.vh"
// How it works
// - Precomp field selects write delay steps
// - Precomp starts at programmed track, default zero
// - Default delay depends on active rate
// - Bit 6 enters low power, data port access or status read leaves
// - Bit 7 is a self-clearing soft reset
// - Written rate-select value readable in shadow
// - Standard rate table and density output
// - Three-mode drive makes code 01 500K
// - Tape type makes code 01 2M
// - Drive density pins follow drive type
// - Main status readable any time, no wait
// - Status bit 0 shows drive zero seeking
// - Status bits 1-3 and 5 read zero
// - Status bit 4 shows command busy
// - Status bit 6 gives transfer direction
// - Status bit 7 allows data port access
// - All bytes pass the one data port
// - FIFO disabled after any reset
// - No FIFO in command phase, flush at execution
// - Overrun or underrun aborts, pad with zeros
// - Service request leaves 16 minus threshold bytes of slack
// - Disk input status read-only, change in bit 7
// - Change flag is inverted pin or forced
// - Hardware reset loads 02, soft reset keeps
// - Rate follows last rate or config write
// - Drive control bit 2 low holds reset
module fhrs_host_port (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Command core status
    input  wire        core_dir,
    input  wire        core_xfer_en,
    input  wire        cmd_busy,
    input  wire        drive_zero_seeking,
    input  wire        core_cmd_phase,
    input  wire        core_exec_start,
    // Command core data side
    input  wire        core_push,
    input  wire [7:0]  core_push_data,
    input  wire        core_pop,
    output reg  [7:0]  core_pop_data,
    output wire        fifo_service_req,
    output reg         xfer_abort,
    // Controller control
    output wire        ctrl_reset,
    output reg         low_power,
    // Rate and precompensation
    input  wire [7:0]  cur_track,
    output reg  [1:0]  rate_code_out,
    output reg  [2:0]  rate_speed,
    output reg         density_select_out,
    output reg  [1:0]  drive_density_pins,
    output reg  [17:0] precomp_delay_ps,
    // Disk cable
    input  wire        media_change_n
);

    // ==========================================================
    // Bus decode
    wire [9:0] idx     = wb_adr_i[11:2];
    wire       take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr      = take & wb_we_i & wb_sel_i[0];
    wire       rd      = take & ~wb_we_i;
    wire       hit_st  = (idx == `FHRS_IDX_STATUS);
    wire       hit_dat = (idx == `FHRS_IDX_DATA);
    wire       hit_dir = (idx == `FHRS_IDX_DIR);
    wire       hit_dc  = (idx == `FHRS_IDX_DRIVE_CTRL);
    wire       hit_frc = (idx == `FHRS_IDX_FORCE_CHG);
    wire       hit_shd = (idx == `FHRS_IDX_SHADOW);
    wire       hit_cfg = (idx == `FHRS_IDX_CONFIG);

    // ==========================================================
    // State
    reg  [7:0]  rs_q;
    reg  [1:0]  rate_q;
    reg  [7:0]  dc_q;
    reg  [23:0] cfg_q;
    reg         force_q;
    reg  [3:0]  srst_cnt_q;
    reg  [2:0]  chg_s_q;
    reg         chg_lvl_q;
    reg  [7:0]  mem [0:`FHRS_FIFO_DEPTH-1];
    reg  [3:0]  wp_q;
    reg  [3:0]  rp_q;
    reg  [4:0]  cnt_q;
    // Self-clear length as a full word, trimmed to the counter on load
    wire [31:0] srst_cyc = `FHRS_SRST_CYC;

    // Soft reset: drive-control bit low, or the self-clearing pulse
    wire sw_rst = ~dc_q[`FHRS_DC_RESET_N] | (srst_cnt_q != 4'h0);
    assign ctrl_reset = sw_rst;

    // ==========================================================
    // Data port buffer
    // Parameters always go single-byte so the core paces them
    wire       fifo_en = cfg_q[`FHRS_CFG_FIFO_EN] & ~core_cmd_phase;
    wire       empty   = (cnt_q == 5'h00);
    wire       full    = fifo_en ? (cnt_q == 5'h10) : ~empty;
    wire [4:0] free    = 5'h10 - cnt_q;
    wire [4:0] thr     = {1'b0, cfg_q[`FHRS_CFG_THR_HI:`FHRS_CFG_THR_LO]};
    wire       host_request = core_xfer_en & (core_dir ? ~empty : ~full);
    // Wrong-direction host accesses, writes when full and reads when empty are dropped
    wire       h_push  = wr & hit_dat & ~core_dir & ~full;
    wire       h_pop   = rd & hit_dat & core_dir & ~empty;
    wire       c_push  = core_push & core_dir & ~full;
    wire       c_pop   = core_pop & ~core_dir & ~empty;
    wire       overrun = core_push & core_dir & full;
    wire       underrun = core_pop & ~core_dir & empty;
    wire       push    = h_push | c_push;
    wire       pop     = h_pop | c_pop;
    wire [7:0] wdata   = core_dir ? core_push_data : wb_dat_i[7:0];
    wire       flush   = sw_rst | core_exec_start;

    // Request at threshold bytes held or free, so host has 16 minus that in byte times
    assign fifo_service_req = core_xfer_en &
        ((fifo_en && thr != 5'h00) ?
         (core_dir ? (cnt_q >= thr) : (free >= thr)) :
         host_request);

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp_q] <= wdata;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n || flush) begin
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end else begin
            if (push) begin
                wp_q <= wp_q + 4'h1;
            end
            if (pop) begin
                rp_q <= rp_q + 4'h1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 5'h01;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end

    // Empty pop hands the core zeros so a write sector is padded
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            core_pop_data <= 8'h00;
            xfer_abort    <= 1'b0;
        end else begin
            xfer_abort <= overrun | underrun;
            if (core_pop) begin
                core_pop_data <= c_pop ? mem[rp_q] : 8'h00;
            end
        end
    end

    // ==========================================================
    // Media change input, three stages, change on agreement
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            chg_s_q   <= 3'b111;
            chg_lvl_q <= 1'b1;
        end else begin
            chg_s_q <= {chg_s_q[1:0], media_change_n};
            if (chg_s_q[1] == chg_s_q[2]) begin
                chg_lvl_q <= chg_s_q[2];
            end
        end
    end

    wire media_changed_flag = ~chg_lvl_q | force_q;

    // ==========================================================
    // Software registers
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            rs_q       <= `FHRS_RS_RESET;
            rate_q     <= `FHRS_RATE_250K;
            dc_q       <= `FHRS_DC_RESET;
            cfg_q      <= `FHRS_CFG_RESET;
            force_q    <= 1'b0;
            srst_cnt_q <= 4'h0;
            low_power  <= 1'b0;
        end else begin
            if (srst_cnt_q != 4'h0) begin
                srst_cnt_q <= srst_cnt_q - 4'h1;
            end
            if (srst_cnt_q == 4'h1) begin
                rs_q[`FHRS_RS_SRST] <= 1'b0;
            end
            // A soft reset keeps rate select but drops FIFO mode
            if (sw_rst) begin
                cfg_q[`FHRS_CFG_FIFO_EN] <= 1'b0;
            end
            if (sw_rst || (take && hit_dat) || (rd && hit_st)) begin
                low_power <= 1'b0;
            end
            if (wr && hit_st) begin
                rs_q   <= wb_dat_i[7:0];
                rate_q <= wb_dat_i[1:0];
                if (wb_dat_i[`FHRS_RS_LP]) begin
                    low_power <= 1'b1;
                end
                if (wb_dat_i[`FHRS_RS_SRST]) begin
                    srst_cnt_q <= srst_cyc[3:0];
                end
            end
            if (wr && hit_dir) begin
                rate_q <= wb_dat_i[1:0];
            end
            if (wr && hit_dc) begin
                dc_q <= wb_dat_i[7:0];
            end
            if (wr && hit_frc) begin
                force_q <= wb_dat_i[0];
            end
            if (wr && hit_cfg && wb_sel_i == 4'hf) begin
                cfg_q <= wb_dat_i[23:0];
            end
        end
    end

    // ==========================================================
    // Bus answer: one cycle after the request is taken
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= take;
            if (rd) begin
                wb_dat_o <= 32'h00000000;
                if (hit_st) begin
                    wb_dat_o[7:0] <= {host_request,
                                      core_dir,
                                      1'b0,
                                      cmd_busy,
                                      3'b000,
                                      drive_zero_seeking};
                end else if (hit_dat) begin
                    wb_dat_o[7:0] <= h_pop ? mem[rp_q] : 8'h00;
                end else if (hit_dir) begin
                    wb_dat_o[7:0] <= {media_changed_flag, 7'h00};
                end else if (hit_dc) begin
                    wb_dat_o[7:0] <= dc_q;
                end else if (hit_frc) begin
                    wb_dat_o[0] <= force_q;
                end else if (hit_shd) begin
                    wb_dat_o[7:0] <= rs_q;
                end else if (hit_cfg) begin
                    wb_dat_o[23:0] <= cfg_q;
                end
            end
        end
    end

    // ==========================================================
    // Rate, density and precompensation
    wire [1:0] drive_rate_type = cfg_q[`FHRS_CFG_DRT_HI:`FHRS_CFG_DRT_LO];
    wire [1:0] dtb = cfg_q[`FHRS_CFG_DT_HI:`FHRS_CFG_DT_LO];
    wire [2:0] pc_code = rs_q[`FHRS_RS_PC_HI:`FHRS_RS_PC_LO];
    reg  [2:0]  spd_d;
    reg         den_d;
    reg  [1:0]  pins_d;
    reg  [17:0] step_d;
    reg  [17:0] def_d;
    reg  [17:0] pc_d;

    always @* begin
        case (rate_q)
            `FHRS_RATE_1M:   spd_d = `FHRS_SPD_1M;
            `FHRS_RATE_500K: spd_d = `FHRS_SPD_500K;
            `FHRS_RATE_250K: spd_d = `FHRS_SPD_250K;
            default: begin
                if (drive_rate_type == `FHRS_DRT_THREE_MODE) begin
                    spd_d = `FHRS_SPD_500K;
                end else if (drive_rate_type == `FHRS_DRT_TAPE) begin
                    spd_d = `FHRS_SPD_2M;
                end else begin
                    spd_d = `FHRS_SPD_300K;
                end
            end
        endcase
        den_d = (rate_q == `FHRS_RATE_1M) || (rate_q == `FHRS_RATE_500K);
        case (dtb)
            2'b00:   pins_d = {rate_q[0], den_d};
            2'b10:   pins_d = {rate_q[0], rate_q[1]};
            2'b01:   pins_d = {rate_q[0], ~den_d};
            default: pins_d = {rate_q[1], rate_q[0]};
        endcase
        step_d = (spd_d == `FHRS_SPD_2M) ? `FHRS_PC_STEP_2M_PS : `FHRS_PC_STEP_PS;
        if (spd_d == `FHRS_SPD_2M) begin
            def_d = `FHRS_PC_STEP_2M_PS;
        end else if (spd_d == `FHRS_SPD_1M) begin
            def_d = `FHRS_PC_STEP_PS;
        end else begin
            def_d = `FHRS_PC_DEF_PS;
        end
        if (cur_track < cfg_q[`FHRS_CFG_TRK_HI:`FHRS_CFG_TRK_LO]) begin
            pc_d = 18'h00000;
        end else if (pc_code == `FHRS_PC_DEF_CODE) begin
            pc_d = def_d;
        end else begin
            pc_d = step_d * {15'h0000, pc_code};
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            rate_code_out      <= 2'b00;
            rate_speed         <= 3'h0;
            density_select_out <= 1'b0;
            drive_density_pins <= 2'b00;
            precomp_delay_ps   <= 18'h00000;
        end else begin
            rate_code_out      <= rate_q;
            rate_speed         <= spd_d;
            density_select_out <= den_d;
            drive_density_pins <= pins_d;
            precomp_delay_ps   <= pc_d;
        end
    end

endmodule

// File: dv/fhrs_host_port_asserts.sv
`timescale 1ns/1ns
// ==========
// Port checker
module fhrs_host_port_asserts (
    // Clock and bus
    input wire        sys_clk,
    input wire        rst_n,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Status and rate
    input wire        core_xfer_en,
    input wire        cmd_busy,
    input wire        drive_zero_seeking,
    input wire [1:0]  rate_code_out,
    input wire [2:0]  rate_speed,
    input wire        density_select_out
);
    // Rate outputs only settle a cycle after reset release
    reg [1:0] live_q;
    always @(posedge sys_clk) begin
        if (!rst_n)
            live_q <= 2'h0;
        else if (!live_q[1])
            live_q <= live_q + 2'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [11:0] a);
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
    endsequence
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    chk_status_zero: assert property (
        s_rd(12'hfd0) |=> (wb_dat_o & 32'hffffff2e) == 32'h0) else $error("status zeros");
    chk_status_live: assert property (
        s_rd(12'hfd0) |=> wb_dat_o[0] == $past(drive_zero_seeking)
        && wb_dat_o[4] == $past(cmd_busy)) else $error("status bits");
    chk_request_gate: assert property (
        s_rd(12'hfd0) ##0 !core_xfer_en |=> !wb_dat_o[7]) else $error("request bit");
    chk_dir_zeros: assert property (
        s_rd(12'hfdc) |=> (wb_dat_o & 32'hffffff7f) == 32'h0) else $error("input zeros");
    chk_rate_density: assert property (
        live_q[1] |-> density_select_out == (rate_code_out == 2'h3 || rate_code_out == 2'h0))
        else $error("density");
    chk_rate_speed: assert property (
        live_q[1] |-> (rate_code_out == 2'h3) == (rate_speed == 3'h3)
        && (rate_code_out == 2'h2) == (rate_speed == 3'h0)) else $error("speed");
endmodule
bind fhrs_host_port fhrs_host_port_asserts chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_xfer_en(core_xfer_en), .cmd_busy(cmd_busy), .drive_zero_seeking(drive_zero_seeking),
    .rate_code_out(rate_code_out), .rate_speed(rate_speed),
    .density_select_out(density_select_out));

// File: dv/fhrs_host_model.sv
`timescale 1ns/1ns
// ==========
// Host processor, classic bus master
module fhrs_host_model (
    // Bus
    input wire        sys_clk,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    output reg        cyc,
    output reg        stb,
    output reg        we,
    output reg [11:0] adr,
    output reg [31:0] dat,
    output reg [3:0]  sel
);
    initial {cyc, stb, we, adr, dat, sel} = 0;
    // Request held until ack is sampled, then released; next call idles a cycle
    task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s, output [31:0] q);
        @(posedge sys_clk);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
        @(posedge sys_clk);
        while (wb_ack_o !== 1'h1)
            @(posedge sys_clk);
        q = wb_dat_o;
        {cyc, stb, we} <= 3'h0;
    endtask
    task poll(output [31:0] q);
        reg [31:0] s;
        begin
            s = 0;
            while (s[7] !== 1'h1)
                xfer(1'h0, 12'hfd0, 32'h0, 4'hf, s);
            xfer(1'h0, 12'hfd4, 32'h0, 4'hf, q);
        end
    endtask
endmodule

// File: dv/test_floppy_host_rate_status_fifo.sv
`timescale 1ns/1ns
module test_floppy_host_rate_status_fifo;
    reg         sys_clk, rst_n, dir, xen, busy, seek, cph, exs, push, pop, mchg_n;
    reg  [7:0]  pdat, trk;
    wire        cyc, stb, we, ack, svc, abort, ctrl_reset, low_power, dens;
    wire [11:0] adr;
    wire [31:0] wdat, rdat;
    wire [3:0]  sel;
    wire [7:0]  pop_data;
    wire [1:0]  code, pins;
    wire [2:0]  speed;
    wire [17:0] pc_ps;
    reg  [31:0] q;
    integer     n_errors, num_checks, i, t, c;
    fhrs_host_model host (.sys_clk(sys_clk), .wb_dat_o(rdat), .wb_ack_o(ack), .cyc(cyc),
        .stb(stb), .we(we), .adr(adr), .dat(wdat), .sel(sel));
    fhrs_host_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .core_dir(dir), .core_xfer_en(xen), .cmd_busy(busy),
        .drive_zero_seeking(seek), .core_cmd_phase(cph), .core_exec_start(exs),
        .core_push(push), .core_push_data(pdat), .core_pop(pop), .core_pop_data(pop_data),
        .fifo_service_req(svc), .xfer_abort(abort), .ctrl_reset(ctrl_reset),
        .low_power(low_power), .cur_track(trk), .rate_code_out(code), .rate_speed(speed),
        .density_select_out(dens), .drive_density_pins(pins), .precomp_delay_ps(pc_ps),
        .media_change_n(mchg_n));
    // ==========
    // Helpers
    task chk(input [31:0] e, input [31:0] g, input string nm);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task w(input [11:0] a, input [31:0] d);
        host.xfer(1'h1, a, d, 4'hf, q);
    endtask
    task r(input [11:0] a);
        host.xfer(1'h0, a, 32'h0, 4'hf, q);
    endtask
    task core(input [4:0] v);
        @(posedge sys_clk);
        {dir, xen, busy, seek, cph} <= v;
    endtask
    task put(input [7:0] d);
        @(posedge sys_clk);
        push <= 1'h1;
        pdat <= d;
        @(posedge sys_clk);
        push <= 1'h0;
    endtask
    // Pulses pop when k is set, the execution start otherwise
    task strobe(input k);
        @(posedge sys_clk);
        {pop, exs} <= {k, !k};
        @(posedge sys_clk);
        {pop, exs} <= 2'h0;
        #1;
    endtask
    function [5:0] rexp(input [1:0] drive_rate_type, input [1:0] dt, input [1:0] cd);
        reg [2:0] s;
        reg       d;
        reg [1:0] p;
        begin
            s = cd == 2'h3 ? 3'h3 : cd == 2'h0 ? 3'h2 : cd == 2'h2 ? 3'h0 :
                drive_rate_type == 2'h1 ? 3'h2 : drive_rate_type == 2'h2 ? 3'h4 : 3'h1;
            d = cd == 2'h3 || cd == 2'h0;
            case (dt)
                2'h0: p = {cd[0], d};
                2'h2: p = {cd[0], cd[1]};
                2'h1: p = {cd[0], !d};
                default: p = {cd[1], cd[0]};
            endcase
            rexp = {s, d, p};
        end
    endfunction
    // ==========
    // Scenarios
    task t_reset;
        chk(2'h2, code, "rate code");
        chk(18'h0, pc_ps, "precomp");
        chk(1'h1, ctrl_reset, "ctrl reset");
        r(12'h07c);
        chk(32'h02, q, "shadow");
        r(12'hfd0);
        chk(32'h0, q, "status");
        for (i = 0; i < 3; i = i + 1) begin
            w(12'hfc8, i == 1 ? 32'h0 : 32'h4);
            tick;
            chk(i == 1, ctrl_reset, "ctrl reset");
        end
    endtask
    task t_rates;
        for (t = 0; t < 4; t = t + 1) begin
            w(12'h080, {20'h0, t[1:0], t == 3 ? 2'h0 : t[1:0], 8'h0});
            for (c = 0; c < 4; c = c + 1) begin
                w(12'hfd0, c);
                tick;
                chk({c[1:0], rexp(t == 3 ? 2'h0 : t[1:0], t[1:0], c[1:0])},
                    {code, speed, dens, pins}, "rate map");
            end
        end
        w(12'h080, 32'h0);
        w(12'hfdc, 32'h3);
        tick;
        chk(2'h3, code, "rate code");
        w(12'hfd0, 32'h2);
        tick;
        chk(2'h2, code, "rate code");
    endtask
    task t_precomp;
        for (i = 0; i < 8; i = i + 1) begin
            w(12'hfd0, {27'h0, i[2:0], 2'h2});
            tick;
            chk(i == 7 ? 18'h1e848 : i * 18'h0a2c6, pc_ps, "precomp");
        end
        w(12'hfd0, 32'h1f);
        tick;
        chk(18'h0a2c6, pc_ps, "precomp");
        w(12'h080, 32'h200);
        w(12'hfd0, 32'h05);
        tick;
        chk(18'h05140, pc_ps, "precomp");
        w(12'hfd0, 32'h1d);
        tick;
        chk(18'h05140, pc_ps, "precomp");
        w(12'h080, 32'h050000);
        w(12'hfd0, 32'h06);
        tick;
        chk(18'h0, pc_ps, "precomp");
        @(posedge sys_clk);
        trk <= 8'h05;
        tick;
        tick;
        chk(18'h0a2c6, pc_ps, "precomp");
        w(12'h080, 32'h0);
        w(12'hfd0, 32'h02);
    endtask
    task t_status;
        core(5'h0e);
        r(12'hfd0);
        chk(32'h91, q, "status");
        core(5'h18);
        r(12'hfd0);
        chk(32'h40, q, "status");
    endtask
    task t_data;
        put(8'ha5);
        host.poll(q);
        chk(32'ha5, q, "data port");
        r(12'hfd4);
        chk(32'h0, q, "data port");
        put(8'h11);
        put(8'h22);
        #1;
        chk(1'h1, abort, "abort");
        strobe(1'h0);
        core(5'h08);
        r(12'hfd0);
        chk(32'h80, q, "status");
        w(12'hfd4, 32'h3c);
        strobe(1'h1);
        chk(8'h3c, pop_data, "pop data");
        strobe(1'h1);
        chk({1'h1, 8'h0}, {abort, pop_data}, "underrun");
    endtask
    task t_fifo;
        core(5'h18);
        w(12'h080, 32'h41);
        for (i = 1; i < 4; i = i + 1)
            put(i);
        #1;
        chk(1'h0, svc, "service");
        put(8'h04);
        #1;
        chk(1'h1, svc, "service");
        strobe(1'h0);
        r(12'hfd0);
        chk(32'h40, q, "status");
        core(5'h19);
        put(8'h05);
        put(8'h06);
        #1;
        chk(1'h1, abort, "abort");
        core(5'h18);
        strobe(1'h0);
    endtask
    task t_power;
        w(12'hfd0, 32'h42);
        tick;
        chk(1'h1, low_power, "low power");
        r(12'hfd0);
        tick;
        chk(1'h0, low_power, "low power");
        w(12'hfd0, 32'h42);
        r(12'hfd4);
        tick;
        chk(1'h0, low_power, "low power");
        w(12'hfd0, 32'h83);
        tick;
        chk(1'h1, ctrl_reset, "soft reset");
        repeat (12) tick;
        chk({1'h0, 2'h3}, {ctrl_reset, code}, "soft reset");
        r(12'h07c);
        chk(32'h03, q, "shadow");
        put(8'h07);
        put(8'h08);
        #1;
        chk(1'h1, abort, "abort");
        w(12'hfd0, 32'h02);
    endtask
    task t_dir;
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge sys_clk);
            mchg_n <= i != 0;
            w(12'h078, i == 2);
            repeat (6) tick;
            r(12'hfdc);
            chk(i == 1 ? 32'h0 : 32'h80, q, "disk input");
        end
        r(12'h100);
        chk(32'h0, q, "unmapped");
    endtask
    task complete_run;
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========
    // Run
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        {rst_n, dir, xen, busy, seek, cph, exs, push, pop, pdat, trk} = 0;
        mchg_n = 1'h1;
        n_errors = 0;
        num_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'h1;
        tick;
        tick;
        t_reset;
        t_rates;
        t_precomp;
        t_status;
        t_data;
        t_fifo;
        t_power;
        t_dir;
        complete_run;
    end
endmodule
